// [src/sdcc_ctrl.v]
`timescale 1ns/100ps
`include "sdcc_map.vh"
module sdcc_ctrl #(
    parameter SETTLE_CYC = `SDCC_SETTLE_CYC,
    parameter PRE_DIV_HI = 2
) (
    input wire sys_clk,
    input wire rst,
    input wire master_rst,
    input wire test_en,
    input wire cfg_source_select,
    input wire [9:0] m_pins,
    input wire [2:0] post_div_a_pins,
    input wire post_div_b_half_sel,
    input wire pre_div_pin,
    input wire [1:0] adr_pins,
    input wire scl_in,
    input wire sda_in,
    output wire sda_out,
    output wire sda_oe,
    input wire ref_sel,
    input wire bypass_sel,
    input wire [1:0] out_stop_n,
    input wire ref_clk_in,
    input wire crystal_osc_pins,
    input wire vco_clk_in,
    input wire pll_lock_raw,
    output reg [9:0] pll_m,
    output reg pll_p,
    output reg pll_ref_out,
    output reg out_a,
    output reg out_b,
    output reg lock
);
    // Map a post-divider code onto half its ratio; code 000 falls back to 1
    function [4:0] sdcc_half_ratio;
        input [2:0] code;
        begin
            case (code)
                3'h2: sdcc_half_ratio = 5'h02;
                3'h3: sdcc_half_ratio = 5'h03;
                3'h4: sdcc_half_ratio = 5'h04;
                3'h5: sdcc_half_ratio = 5'h06;
                3'h6: sdcc_half_ratio = 5'h08;
                3'h7: sdcc_half_ratio = 5'h10;
                default: sdcc_half_ratio = 5'h01;
            endcase
        end
    endfunction

    // Every pin input passes two flip-flops before use
    localparam SW = 26;
    wire [SW-1:0] pin_raw = {master_rst, test_en, cfg_source_select, m_pins,
        post_div_a_pins, post_div_b_half_sel, pre_div_pin, ref_sel, bypass_sel,
        out_stop_n, ref_clk_in, crystal_osc_pins, vco_clk_in, pll_lock_raw};
    reg [SW-1:0] pin_s1, pin_s2;
    reg [1:0] adr_s1, adr_s2;
    always @(posedge sys_clk) begin
        pin_s1 <= pin_raw;
        pin_s2 <= pin_s1;
        adr_s1 <= adr_pins; // Strapped pins, but a board may still move them live
        adr_s2 <= adr_s1;
    end
    wire mr_s = pin_s2[25];
    wire test_s = pin_s2[24];
    wire src_s = pin_s2[23];
    wire [9:0] m_s = pin_s2[22:13];
    wire [2:0] na_s = pin_s2[12:10];
    wire nb_s = pin_s2[9];
    wire p_s = pin_s2[8];
    wire rsel_s = pin_s2[7];
    wire byp_s = pin_s2[6];
    wire [1:0] stop_n_s = pin_s2[5:4];
    wire refx_s = pin_s2[3];
    wire xtal_s = pin_s2[2];
    wire vco_s = pin_s2[1];
    wire lock_s = pin_s2[0];

    // Master reset acts just like the system reset on all configuration state
    wire int_rst = rst | mr_s; // R16

    wire [9:0] reg_m;
    wire [2:0] reg_na;
    wire reg_nb, reg_p, reg_wr;
    sdcc_serial_slave u_slave (
        .sys_clk(sys_clk),
        .rst(int_rst),
        .adr_pins(adr_s2),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .sda_out(sda_out),
        .sda_oe(sda_oe),
        .reg_m(reg_m),
        .reg_na(reg_na),
        .reg_nb(reg_nb),
        .reg_p(reg_p),
        .reg_wr(reg_wr)
    );

    // Active divider settings: pins when select is low, serial registers when high
    reg [2:0] na_act;
    reg nb_act;
    always @(posedge sys_clk) begin
        if (int_rst) begin
            pll_m <= `SDCC_M_DEF; // R19
            pll_p <= `SDCC_P_DEF;
            na_act <= `SDCC_NA_DEF;
            nb_act <= `SDCC_NB_DEF;
        end else if (!src_s) begin // R4 R15 R18
            pll_m <= m_s; // R3
            pll_p <= p_s;
            na_act <= na_s;
            nb_act <= nb_s;
        end else begin
            pll_m <= reg_m; // R18
            pll_p <= reg_p;
            na_act <= reg_na;
            nb_act <= reg_nb;
        end
    end

    // Reference select: low takes the external clock, high the crystal
    wire ref_s = rsel_s ? xtal_s : refx_s; // R11 R17
    reg ref_d;
    always @(posedge sys_clk) begin
        ref_d <= ref_s;
    end
    wire ref_rise = ref_s & ~ref_d;

    // Pre-divided reference for the PLL phase detector; only rising edges counted
    reg [4:0] pre_cnt;
    wire [4:0] pre_half = pll_p ? PRE_DIV_HI[5:1] : 5'h00;
    always @(posedge sys_clk) begin
        if (int_rst) begin
            pre_cnt <= 5'h00;
            pll_ref_out <= 1'b0;
        end else if (pre_half == 5'h00) begin
            pll_ref_out <= ref_s; // R12
        end else if (ref_rise) begin
            if (pre_cnt >= pre_half - 5'h01) begin
                pre_cnt <= 5'h00;
                pll_ref_out <= ~pll_ref_out; // R12
            end else begin
                pre_cnt <= pre_cnt + 5'h01;
            end
        end
    end

    // Bypass low feeds the reference to the post-divider, high feeds the VCO
    wire src_clk = byp_s ? vco_s : ref_s; // R14 R20
    reg src_d;
    always @(posedge sys_clk) begin
        src_d <= src_clk;
    end
    wire src_tick = src_clk & ~src_d;

    // Post-divider: toggles phase every half ratio of source edges
    reg [4:0] div_cnt;
    reg ph_a, ph_b;
    wire [4:0] half_a = sdcc_half_ratio(na_act); // R1
    wire div_edge = src_tick && (div_cnt >= half_a - 5'h01);
    always @(posedge sys_clk) begin
        if (int_rst) begin
            div_cnt <= 5'h00;
            ph_a <= 1'b0;
            ph_b <= 1'b0;
        end else if (src_tick) begin
            // A new ratio applies to the count in progress; a count already past it ends the phase at the next edge
            if (div_edge) begin
                div_cnt <= 5'h00;
                ph_a <= ~ph_a; // R1 R13
                if (!ph_a)
                    ph_b <= ~ph_b;
            end else begin
                div_cnt <= div_cnt + 5'h01;
            end
        end
    end

    // Second output follows first, or takes half rate on each first-output rise
    wire next_b_phase = nb_act ? ph_b : ph_a; // R2

    // Stop gating: enables change only while the gated output is low,
    // so a stop or restart never clips a high pulse
    reg en_a, en_b;
    always @(posedge sys_clk) begin
        if (int_rst) begin
            en_a <= 1'b0;
            en_b <= 1'b0;
            out_a <= 1'b0;
            out_b <= 1'b0;
        end else begin
            if (!out_a && !ph_a)
                en_a <= stop_n_s[0]; // R8 R9
            if (!out_b && !next_b_phase)
                en_b <= stop_n_s[1]; // R8 R9
            out_a <= ph_a & en_a; // R9
            out_b <= next_b_phase & en_b; // R9
        end
    end

    // Lock qualification: any divider change or reset restarts the settle wait
    reg [9:0] m_prev;
    reg [2:0] na_prev;
    reg nb_prev, p_prev;
    reg [15:0] settle;
    wire cfg_chg = (pll_m != m_prev) || (na_act != na_prev) || (nb_act != nb_prev)
        || (pll_p != p_prev) || reg_wr;
    always @(posedge sys_clk) begin
        m_prev <= pll_m;
        na_prev <= na_act;
        nb_prev <= nb_act;
        p_prev <= pll_p;
        if (int_rst) begin
            settle <= 16'h0000; // R21
            lock <= 1'b0;
        end else begin
            if (cfg_chg || !lock_s)
                settle <= 16'h0000; // R21
            else if (settle != SETTLE_CYC[15:0])
                settle <= settle + 16'h0001;
            // Test mode must stay low; if it is raised the lock cannot be trusted
            lock <= lock_s && !cfg_chg && !test_s // R7 R10
                && (settle == SETTLE_CYC[15:0]); // R21
        end
    end
endmodule

// [src/sdcc_map.vh]
// Summary of operation
// R1: Output post-divider offers seven ratios: 2, 4, 6, 8, 12, 16, 32.
// R2: Second output runs at first output rate or at half of it.
// R3: In parallel mode all divider settings come straight from the pins.
// R4: Parallel interface has priority over the serial interface.
// R5: Serial slave can read and write the divider configuration registers.
// R6: Two bits of the serial slave address come from the address pins.
// R7: A status output shows whether the PLL is locked.
// R8: Each output is disabled while its stop input is low.
// R9: Outputs stop and restart synchronously, with no runt pulses.
// R10: System holds the factory test enable low in normal operation.
// R11: Reference select picks crystal or external reference clock.
// R12: Reference is divided by the pre-divider before PLL multiplication.
// R13: Divider settings may change while running, without reset.
// R14: Bypass select routes the reference around the PLL.
// R15: Interface select decides whether pins or serial bus set dividers.
// R16: Master reset returns the configuration logic to its reset state.
// R17: Reference select low uses external clock, high uses crystal.
// R18: Interface select low takes pins, high takes serial registers.
// R19: Defaults: feedback 0111110100b, post code 010, half 0, pre 1.
// R20: Bypass low divides reference by post-dividers; high uses the PLL.
// R21: Lock drops on divider change or master reset, returns after relock.
`ifndef SDCC_MAP_VH
`define SDCC_MAP_VH
// Default divider settings
`define SDCC_M_DEF 10'h1F4
`define SDCC_NA_DEF 3'h2
`define SDCC_NB_DEF 1'b0
`define SDCC_P_DEF 1'b1
// Serial register indices and field positions of register 0
`define SDCC_REG_CTRL 1'b0
`define SDCC_REG_MLOW 1'b1
`define SDCC_F_P 7
`define SDCC_F_NB 6
`define SDCC_F_NA_HI 5
`define SDCC_F_NA_LO 3
`define SDCC_F_MHI_HI 1
`define SDCC_F_MHI_LO 0
// Upper five bits of the serial slave address
`define SDCC_ADDR_BASE 5'h1A
// Serial protocol phases
`define SDCC_PH_IDLE 3'h0
`define SDCC_PH_ADDR 3'h1
`define SDCC_PH_PTR 3'h2
`define SDCC_PH_WR 3'h3
`define SDCC_PH_RD 3'h4
// Relock settle time and clock period in ns
`define SDCC_SETTLE_NS 5000
`define SDCC_CLK_NS 50
`define SDCC_SETTLE_CYC (`SDCC_SETTLE_NS / `SDCC_CLK_NS)
`endif

// [src/sdcc_serial_slave.v]
`timescale 1ns/100ps
`include "sdcc_map.vh"
module sdcc_serial_slave (
    input wire sys_clk,
    input wire rst,
    input wire [1:0] adr_pins,
    input wire scl_in,
    input wire sda_in,
    output wire sda_out,
    output reg sda_oe,
    output reg [9:0] reg_m,
    output reg [2:0] reg_na,
    output reg reg_nb,
    output reg reg_p,
    output reg reg_wr
);
    reg scl_s1, scl_s2, scl_d;
    reg sda_s1, sda_s2, sda_d;
    reg [2:0] phase;
    reg [3:0] bitc;
    reg [7:0] shreg;
    reg ptr;
    wire scl_rise = scl_s2 & ~scl_d;
    wire scl_fall = ~scl_s2 & scl_d;
    wire start_c = scl_s2 & scl_d & sda_d & ~sda_s2;
    wire stop_c = scl_s2 & scl_d & ~sda_d & sda_s2;
    wire [6:0] my_addr = {`SDCC_ADDR_BASE, adr_pins}; // R6
    wire [7:0] rdata = (ptr == `SDCC_REG_CTRL) ? {reg_p, reg_nb, reg_na, 1'b0, reg_m[9:8]}
        : reg_m[7:0];

    // Open drain: only ever pulls low
    assign sda_out = 1'b0;

    // Two-stage synchronisers, then one delay stage for edge finding
    always @(posedge sys_clk) begin
        scl_s1 <= scl_in;
        scl_s2 <= scl_s1;
        scl_d <= scl_s2;
        sda_s1 <= sda_in;
        sda_s2 <= sda_s1;
        sda_d <= sda_s2;
    end

    // Protocol engine; registers may be written at any time, even while running
    always @(posedge sys_clk) begin
        reg_wr <= 1'b0;
        if (rst) begin
            phase <= `SDCC_PH_IDLE;
            bitc <= 4'h0;
            shreg <= 8'h00;
            ptr <= 1'b0;
            sda_oe <= 1'b0;
            reg_m <= `SDCC_M_DEF; // R19
            reg_na <= `SDCC_NA_DEF;
            reg_nb <= `SDCC_NB_DEF;
            reg_p <= `SDCC_P_DEF;
        end else if (start_c) begin
            phase <= `SDCC_PH_ADDR;
            bitc <= 4'h0;
            sda_oe <= 1'b0;
        end else if (stop_c) begin
            phase <= `SDCC_PH_IDLE;
            sda_oe <= 1'b0;
        end else if (scl_rise && phase != `SDCC_PH_IDLE) begin
            if (bitc != 4'h8) begin
                if (phase != `SDCC_PH_RD)
                    shreg <= {shreg[6:0], sda_s2};
                bitc <= bitc + 4'h1;
            end else begin
                bitc <= 4'h0;
                // Master not acknowledging ends the read
                if (phase == `SDCC_PH_RD && sda_s2)
                    phase <= `SDCC_PH_IDLE;
            end
        end else if (scl_fall && phase != `SDCC_PH_IDLE) begin
            if (bitc == 4'h8) begin
                case (phase)
                    `SDCC_PH_ADDR: begin
                        if (shreg[7:1] == my_addr) begin
                            sda_oe <= 1'b1;
                            phase <= shreg[0] ? `SDCC_PH_RD : `SDCC_PH_PTR;
                        end else begin
                            phase <= `SDCC_PH_IDLE;
                        end
                    end
                    `SDCC_PH_PTR: begin
                        ptr <= shreg[0];
                        sda_oe <= 1'b1;
                        phase <= `SDCC_PH_WR;
                    end
                    `SDCC_PH_WR: begin
                        // Byte write with pointer auto-increment
                        if (ptr == `SDCC_REG_CTRL) begin // R5
                            reg_p <= shreg[`SDCC_F_P];
                            reg_nb <= shreg[`SDCC_F_NB];
                            reg_na <= shreg[`SDCC_F_NA_HI:`SDCC_F_NA_LO];
                            reg_m[9:8] <= shreg[`SDCC_F_MHI_HI:`SDCC_F_MHI_LO];
                        end else begin
                            reg_m[7:0] <= shreg;
                        end
                        reg_wr <= 1'b1; // R13
                        ptr <= ~ptr;
                        sda_oe <= 1'b1;
                    end
                    default: sda_oe <= 1'b0;
                endcase
            end else if (phase == `SDCC_PH_RD) begin
                if (bitc == 4'h0) begin
                    shreg <= rdata; // R5
                    sda_oe <= ~rdata[7];
                    ptr <= ~ptr;
                end else begin
                    sda_oe <= ~shreg[3'd7 - bitc[2:0]];
                end
            end else begin
                sda_oe <= 1'b0;
            end
        end
    end
endmodule

// [verif/sdcc_ctrl_sva.sv]
`timescale 1ns/100ps
module sdcc_ctrl_chk #(
    parameter SETTLE_CYC = 100
) (
    input wire sys_clk,
    input wire rst,
    input wire master_rst,
    input wire cfg_source_select,
    input wire [9:0] m_pins,
    input wire pre_div_pin,
    input wire [1:0] out_stop_n,
    input wire pll_lock_raw,
    input wire sda_oe,
    input wire [9:0] pll_m,
    input wire pll_p,
    input wire out_a,
    input wire out_b,
    input wire lock
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // Master reset pin acts a few edges late, so it must be held before values are judged
    property p_rst_vals; master_rst [*5] |=> pll_m == 10'h1F4 && pll_p && !lock && !out_a; endproperty
    a_rst_vals: assert property (p_rst_vals) else $error("Master reset values wrong");
    // Lock follows setting changes and the raw lock level
    property p_lock_drop; $changed(pll_m) || $changed(pll_p) |-> ##[0:1] !lock; endproperty
    a_lock_drop: assert property (p_lock_drop) else $error("Lock held over change");
    property p_lock_settle; $rose(lock) |-> pll_m == $past(pll_m, SETTLE_CYC); endproperty
    a_lock_settle: assert property (p_lock_settle) else $error("Lock rose too early");
    property p_lock_raw; (!pll_lock_raw) [*4] |-> !lock; endproperty
    a_lock_raw: assert property (p_lock_raw) else $error("Lock without raw lock");
    // Pins reach the active settings after sync and register, margin for master reset tail
    property p_par_m; (!cfg_source_select && !master_rst && $stable(m_pins)) [*8] |-> pll_m == m_pins;
    endproperty
    a_par_m: assert property (p_par_m) else $error("Feedback pins not applied");
    property p_par_p;
        (!cfg_source_select && !master_rst && $stable(pre_div_pin)) [*8] |-> pll_p == pre_div_pin;
    endproperty
    a_par_p: assert property (p_par_p) else $error("Pre-divider pin not applied");
    // A stopped output never starts a new high phase, and no high phase is clipped
    property p_stop_a; (!out_stop_n[0]) [*4] |-> ##1 !$rose(out_a); endproperty
    a_stop_a: assert property (p_stop_a) else $error("Output A ran while stopped");
    property p_stop_b; (!out_stop_n[1]) [*4] |-> ##1 !$rose(out_b); endproperty
    a_stop_b: assert property (p_stop_b) else $error("Output B ran while stopped");
    property p_runt_a; $rose(out_a) |-> out_a [*3]; endproperty
    a_runt_a: assert property (p_runt_a) else $error("Runt pulse on output A");
    property p_runt_b; $rose(out_b) |-> out_b [*3]; endproperty
    a_runt_b: assert property (p_runt_b) else $error("Runt pulse on output B");
    c_lock: cover property ($rose(lock));
    c_ack: cover property ($rose(sda_oe));
    c_stop: cover property ((!out_stop_n[0]) [*8]);
endmodule

// [verif/sdcc_host_model.sv]
`timescale 1ns/100ps
// Serial host: SCL rests high between frames, SDA is only ever pulled low
module sdcc_host_model (
    output logic scl,
    output logic sda_low,
    input wire sda_line
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // Start is SDA falling while SCL is high
    task automatic bus_start();
        #200 sda_low = 1'b1;
        #200 scl = 1'b0;
        #100;
    endtask
    // Stop is SDA rising while SCL is high; the pull-up then holds the line
    task automatic bus_stop();
        sda_low = 1'b1;
        #100 scl = 1'b1;
        #200 sda_low = 1'b0;
        #200;
    endtask
    // Eight bits MSB first, then a released ninth bit; a one releases SDA for the slave
    task automatic xfer(input logic [7:0] b, output logic [7:0] rd, output logic ack);
        for (int i = 8; i >= 0; i--) begin
            sda_low = (i > 0) ? !b[i - 1] : 1'b0;
            #100 scl = 1'b1;
            #100;
            if (i > 0) rd[i - 1] = sda_line;
            else ack = !sda_line;
            #100 scl = 1'b0;
            #100;
        end
    endtask
endmodule

// [verif/test_synth_divider_config_ctrl.sv]
`timescale 1ns/100ps
module test_synth_divider_config_ctrl;
    localparam int SC = 10;
    logic sys_clk, rst, master_rst, test_en, cfg_source_select, post_div_b_half_sel, pre_div_pin;
    logic ref_sel, bypass_sel, ref_clk_in, crystal_osc_pins, vco_clk_in, pll_lock_raw;
    logic sda_out, sda_oe, pll_p, pll_ref_out, out_a, out_b, lock;
    logic [9:0] m_pins, pll_m;
    logic [2:0] post_div_a_pins;
    logic [1:0] adr_pins, out_stop_n;
    wire scl, host_low;
    // Open-drain SDA with pull-up: low if either side pulls
    wire sda_line = !(host_low || sda_oe);
    int err_count = 0;
    int checked = 0;
    int cyc = 0;
    sdcc_ctrl #(.SETTLE_CYC(SC)) u_sdcc_ctrl (
        .sys_clk, .rst, .master_rst, .test_en, .cfg_source_select, .m_pins, .post_div_a_pins,
        .post_div_b_half_sel, .pre_div_pin, .adr_pins, .scl_in(scl), .sda_in(sda_line), .sda_out,
        .sda_oe, .ref_sel, .bypass_sel, .out_stop_n, .ref_clk_in, .crystal_osc_pins, .vco_clk_in,
        .pll_lock_raw, .pll_m, .pll_p, .pll_ref_out, .out_a, .out_b, .lock
    );
    sdcc_host_model u_sdcc_host_model (.scl(scl), .sda_low(host_low), .sda_line(sda_line));
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    // Slow source clocks, phases unrelated to the system clock
    initial begin
        ref_clk_in = 1'b0;
        crystal_osc_pins = 1'b0;
        vco_clk_in = 1'b0;
        fork
            #7 forever #200 ref_clk_in = ~ref_clk_in;
            #13 forever #300 crystal_osc_pins = ~crystal_osc_pins;
            #3 forever #100 vco_clk_in = ~vco_clk_in;
        join
    end
    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic check_val(input logic [9:0] got, input logic [9:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL %0t value %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check_time(input real got, input real exp);
        checked++;
        if (got < exp - 60.0 || got > exp + 60.0) begin
            err_count++;
            $display("FAIL %0t period %0.1f expected %0.1f", $time, got, exp);
        end
    endtask
    // First rise is discarded since a setting change may leave a partial period
    task automatic period(input int s, output real p);
        real t0;
        for (int k = 0; k < 3; k++) begin
            case (s)
                0: @(posedge out_a);
                1: @(posedge out_b);
                default: @(posedge pll_ref_out);
            endcase
            if (k == 1) t0 = $realtime;
        end
        p = $realtime - t0;
        @(negedge sys_clk);
    endtask
    task automatic t_parallel();
        m_pins = 10'h0AB;
        pre_div_pin = 1'b0;
        tick(5);
        check_val(pll_m, 10'h0AB);
        check_val({9'h0, pll_p}, 10'h0);
        check_val({9'h0, lock}, 10'h0);
        tick(SC + 3);
        check_val({9'h0, lock}, 10'h1);
        pll_lock_raw = 1'b0;
        tick(5);
        check_val({9'h0, lock}, 10'h0);
        pll_lock_raw = 1'b1;
    endtask
    task automatic t_serial();
        logic [7:0] rd;
        logic ack;
        u_sdcc_host_model.bus_start();
        u_sdcc_host_model.xfer(8'hD0, rd, ack);
        u_sdcc_host_model.bus_stop();
        check_val({9'h0, ack}, 10'h0);
        check_val({9'h0, sda_out}, 10'h0);
        u_sdcc_host_model.bus_start();
        u_sdcc_host_model.xfer(8'hD4, rd, ack);
        check_val({9'h0, ack}, 10'h1);
        u_sdcc_host_model.xfer(8'h01, rd, ack);
        u_sdcc_host_model.xfer(8'h55, rd, ack);
        u_sdcc_host_model.bus_stop();
        check_val({9'h0, ack}, 10'h1);
        tick(5);
        check_val(pll_m, 10'h0AB);
        cfg_source_select = 1'b1;
        tick(5);
        check_val(pll_m, 10'h155);
        u_sdcc_host_model.bus_start();
        u_sdcc_host_model.xfer(8'hD4, rd, ack);
        u_sdcc_host_model.xfer(8'h01, rd, ack);
        u_sdcc_host_model.bus_stop();
        u_sdcc_host_model.bus_start();
        u_sdcc_host_model.xfer(8'hD5, rd, ack);
        u_sdcc_host_model.xfer(8'hFF, rd, ack);
        u_sdcc_host_model.bus_stop();
        check_val({2'h0, rd}, 10'h055);
        // Pointer moved on to the control register, which still holds its reset value
        u_sdcc_host_model.bus_start();
        u_sdcc_host_model.xfer(8'hD5, rd, ack);
        u_sdcc_host_model.xfer(8'hFF, rd, ack);
        u_sdcc_host_model.bus_stop();
        check_val({2'h0, rd}, 10'h091);
        cfg_source_select = 1'b0;
        tick(5);
    endtask
    task automatic t_divider();
        int ratio [7] = '{2, 4, 6, 8, 12, 16, 32};
        real p;
        ref_sel = 1'b0;
        for (int c = 1; c < 8; c++) begin
            post_div_a_pins = c[2:0];
            period(0, p);
            check_time(p, ratio[c - 1] * 400.0);
        end
        post_div_a_pins = 3'h1;
        ref_sel = 1'b1;
        period(0, p);
        check_time(p, 1200.0);
        bypass_sel = 1'b1;
        period(0, p);
        check_time(p, 400.0);
        post_div_b_half_sel = 1'b1;
        period(1, p);
        check_time(p, 800.0);
        post_div_b_half_sel = 1'b0;
        period(1, p);
        check_time(p, 400.0);
        ref_sel = 1'b0;
        pre_div_pin = 1'b1;
        period(2, p);
        check_time(p, 800.0);
        pre_div_pin = 1'b0;
        period(2, p);
        check_time(p, 400.0);
    endtask
    task automatic t_stop();
        real p;
        out_stop_n = 2'b10;
        tick(20);
        check_val({9'h0, out_a}, 10'h0);
        period(1, p);
        check_time(p, 400.0);
        out_stop_n = 2'b11;
        period(0, p);
        check_time(p, 400.0);
        out_stop_n = 2'b01;
        tick(20);
        check_val({9'h0, out_b}, 10'h0);
        out_stop_n = 2'b11;
    endtask
    task automatic t_mrst();
        check_val({9'h0, lock}, 10'h1);
        m_pins = 10'h2C3;
        tick(5);
        check_val(pll_m, 10'h2C3);
        check_val({9'h0, lock}, 10'h0);
        master_rst = 1'b1;
        tick(6);
        check_val({pll_m[9:1], lock}, {9'h0FA, 1'b0});
        master_rst = 1'b0;
        tick(8);
        check_val(pll_m, 10'h2C3);
    endtask
    task automatic end_sim();
        $display("checked %0d err_count %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Hang guard: runs are a few thousand cycles
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            end_sim();
        end
    end
    initial begin
        rst = 1'b1;
        master_rst = 1'b0;
        test_en = 1'b0;
        cfg_source_select = 1'b0;
        m_pins = 10'h1F4;
        post_div_a_pins = 3'h2;
        post_div_b_half_sel = 1'b0;
        pre_div_pin = 1'b1;
        adr_pins = 2'b10;
        ref_sel = 1'b1;
        bypass_sel = 1'b0;
        out_stop_n = 2'b11;
        pll_lock_raw = 1'b1;
        tick(8);
        check_val(pll_m, 10'h1F4);
        check_val({6'h0, pll_p, out_a, out_b, lock}, 10'h008);
        rst = 1'b0;
        tick(4);
        t_parallel();
        t_serial();
        t_divider();
        t_stop();
        t_mrst();
        end_sim();
    end
endmodule
bind sdcc_ctrl sdcc_ctrl_chk #(.SETTLE_CYC(SETTLE_CYC)) u_sdcc_ctrl_chk (
    .sys_clk, .rst, .master_rst, .cfg_source_select, .m_pins, .pre_div_pin, .out_stop_n,
    .pll_lock_raw, .sda_oe, .pll_m, .pll_p, .out_a, .out_b, .lock
);
